// ==== src/fcd_defs.svh ====
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH

// unlock and command addresses, word and byte mode
`define FCD_UNLK1_WORD  22'h000555
`define FCD_UNLK2_WORD  22'h0002aa
`define FCD_UNLK1_BYTE  22'h000aaa
`define FCD_UNLK2_BYTE  22'h000555
`define FCD_CFI_WORD    22'h000055
`define FCD_CFI_BYTE    22'h0000aa
`define FCD_ADDR_ZERO   22'h000000

// command codes
`define FCD_D_UNLK1     16'h00aa
`define FCD_D_UNLK2     16'h0055
`define FCD_D_ASEL      16'h0090
`define FCD_D_SEC_ENTER 16'h0088
`define FCD_D_SEC_EXIT  16'h0000
`define FCD_D_PROG      16'h00a0
`define FCD_D_ERASE     16'h0080
`define FCD_D_CHIP      16'h0010
`define FCD_D_SECT      16'h0030
`define FCD_D_RESET     16'h00f0
`define FCD_D_CFI       16'h0098
`define FCD_D_SUSPEND   16'h00b0
`define FCD_D_RESUME    16'h0030

// security region placement
`define FCD_ESN_BASE_BYTE 22'h3f0000
`define FCD_ESN_BASE_WORD 22'h1f8000
`define FCD_SEC_SIZE_BYTE 22'h010000
`define FCD_SEC_SIZE_WORD 22'h008000

// timing, times in their own unit, counts derived at 200 MHz
`define FCD_CLK_MHZ     200
`define FCD_T_WP_NS     35
`define FCD_T_ACC_NS    70
`define FCD_T_GAP_NS    20
`define FCD_T_PWRUP_NS  50000
`define FCD_WP_CYC      ((`FCD_T_WP_NS * `FCD_CLK_MHZ + 999) / 1000)
`define FCD_ACC_CYC     ((`FCD_T_ACC_NS * `FCD_CLK_MHZ + 999) / 1000)
`define FCD_GAP_CYC     ((`FCD_T_GAP_NS * `FCD_CLK_MHZ + 999) / 1000)
`define FCD_PWRUP_CYC   ((`FCD_T_PWRUP_NS * `FCD_CLK_MHZ + 999) / 1000)

`endif

// ==== src/fcd_pkg.sv ====
package fcd_pkg;

    typedef enum logic [3:0] {
        FCD_OP_READ       = 4'h0,
        FCD_OP_RESET      = 4'h1,
        FCD_OP_ASEL       = 4'h2,
        FCD_OP_SEC_ENTER  = 4'h3,
        FCD_OP_SEC_EXIT   = 4'h4,
        FCD_OP_PROG       = 4'h5,
        FCD_OP_CHIP_ERASE = 4'h6,
        FCD_OP_SECT_ERASE = 4'h7,
        FCD_OP_CFI        = 4'h8,
        FCD_OP_SUSPEND    = 4'h9,
        FCD_OP_RESUME     = 4'ha,
        FCD_OP_ESN_READ   = 4'hb
    } fcd_op_t;

    typedef struct packed {
        logic        wr;
        logic [21:0] addr;
        logic [15:0] data;
    } fcd_step_t;

endpackage : fcd_pkg

// ==== src/fcd_cyc_if.sv ====
`timescale 1ns/1ps
// one bus cycle request from the sequencer to the pin driver
interface fcd_cyc_if;
    logic        req;
    logic        wr;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
    modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
    modport drv  (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fcd_cyc_if

// ==== src/fcd_cycle.sv ====
`timescale 1ns/1ps
`include "fcd_defs.svh"
module fcd_cycle
    import fcd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_sync_b,
    fcd_cyc_if.drv           cyc,
    input  wire logic [15:0] fl_dq_i,
    output logic      [21:0] fl_addr,
    output logic      [15:0] fl_dq_o,
    output logic             fl_dq_oe,
    output logic             fl_ce_b,
    output logic             fl_we_b,
    output logic             fl_oe_b
);
    typedef enum logic [4:0] {
        FCD_C_IDLE   = 5'b00001,
        FCD_C_SETUP  = 5'b00010,
        FCD_C_STROBE = 5'b00100,
        FCD_C_HOLD   = 5'b01000,
        FCD_C_GAP    = 5'b10000
    } fcd_cph_t;

    fcd_cph_t   ph_r;
    logic [3:0] cnt_r;
    logic       wr_r;

    // address and chip select lead, strobe falls later, data held past the rising edge
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ph_r      <= FCD_C_IDLE;
            cnt_r     <= 4'h0;
            wr_r      <= 1'b0;
            cyc.done  <= 1'b0;
            cyc.rdata <= 16'h0000;
            fl_addr   <= 22'h000000;
            fl_dq_o   <= 16'h0000;
            fl_dq_oe  <= 1'b0;
            fl_ce_b   <= 1'b1;
            fl_we_b   <= 1'b1;
            fl_oe_b   <= 1'b1;
        end else begin
            cyc.done <= 1'b0;
            unique case (ph_r)
                FCD_C_IDLE: begin
                    if (cyc.req) begin
                        wr_r     <= cyc.wr;
                        fl_addr  <= cyc.addr;
                        fl_dq_o  <= cyc.wdata;
                        fl_dq_oe <= cyc.wr;
                        fl_ce_b  <= 1'b0;
                        ph_r     <= FCD_C_SETUP;
                    end
                end
                FCD_C_SETUP: begin
                    // write only with output enable high, read never with write strobe low
                    fl_we_b <= ~wr_r;
                    fl_oe_b <= wr_r;
                    cnt_r   <= wr_r ? 4'(`FCD_WP_CYC - 1) : 4'(`FCD_ACC_CYC - 1);
                    ph_r    <= FCD_C_STROBE;
                end
                FCD_C_STROBE: begin
                    if (cnt_r == 4'h0) begin
                        fl_we_b <= 1'b1;
                        fl_oe_b <= 1'b1;
                        if (!wr_r) begin
                            cyc.rdata <= fl_dq_i;
                        end
                        ph_r <= FCD_C_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                FCD_C_HOLD: begin
                    fl_ce_b  <= 1'b1;
                    fl_dq_oe <= 1'b0;
                    cnt_r    <= 4'(`FCD_GAP_CYC - 1);
                    ph_r     <= FCD_C_GAP;
                end
                FCD_C_GAP: begin
                    if (cnt_r == 4'h0) begin
                        cyc.done <= 1'b1;
                        ph_r     <= FCD_C_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
            endcase
        end
    end

endmodule : fcd_cycle

// ==== src/fcd_host.sv ====
`timescale 1ns/1ps
`include "fcd_defs.svh"
module fcd_host
    import fcd_pkg::*;
#(
    parameter int unsigned PWRUP_CYC = `FCD_PWRUP_CYC,
    parameter bit          TOP_BOOT  = 1'b0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        byte_mode,
    input  wire logic        supply_low,
    input  wire logic        sec_locked,
    input  wire logic        cmd_valid,
    input  wire fcd_op_t     cmd_op,
    input  wire logic [21:0] cmd_addr,
    input  wire logic [15:0] cmd_data,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic             rsp_err,
    output logic      [15:0] rsp_data,
    output logic             in_secure,
    output logic             in_autosel,
    output logic             erase_active,
    output logic             erase_suspended,
    input  wire logic [15:0] fl_dq_i,
    input  wire logic        fl_rdy,
    output logic      [21:0] fl_addr,
    output logic      [15:0] fl_dq_o,
    output logic             fl_dq_oe,
    output logic             fl_ce_b,
    output logic             fl_we_b,
    output logic             fl_oe_b,
    output logic             fl_reset_b
);
    typedef enum logic [4:0] {
        FCD_S_PWR  = 5'b00001,
        FCD_S_IDLE = 5'b00010,
        FCD_S_STEP = 5'b00100,
        FCD_S_WAIT = 5'b01000,
        FCD_S_RSP  = 5'b10000
    } fcd_state_t;

    fcd_cyc_if  cyc ();
    fcd_state_t st_r;
    fcd_op_t    op_r;
    logic [21:0] addr_r;
    logic [15:0] data_r;
    logic [2:0]  idx_r;
    logic [2:0]  last_r;
    logic        pre_rst_r;
    logic [31:0] pwr_cnt_r;
    logic        rst_meta_r;
    logic        rst_sync_r;
    logic        rdy_d_r;
    fcd_step_t   step;

    // address falls inside the window that the boot sectors give the security region
    function automatic logic in_window(input logic [21:0] a, input logic bm);
        logic [21:0] base;
        logic [21:0] size;
        base = bm ? `FCD_ESN_BASE_BYTE : `FCD_ESN_BASE_WORD;
        size = bm ? `FCD_SEC_SIZE_BYTE : `FCD_SEC_SIZE_WORD;
        in_window = TOP_BOOT ? (a >= base) : (a < size);
    endfunction : in_window

    // one bus cycle of a command sequence
    function automatic fcd_step_t step_of(input fcd_op_t op, input logic [2:0] i, input logic bm,
                                          input logic [21:0] a, input logic [15:0] d);
        logic [21:0] u1;
        logic [21:0] u2;
        u1 = bm ? `FCD_UNLK1_BYTE : `FCD_UNLK1_WORD;
        u2 = bm ? `FCD_UNLK2_BYTE : `FCD_UNLK2_WORD;
        step_of = '{1'b1, `FCD_ADDR_ZERO, `FCD_D_RESET};
        unique case (op)
            FCD_OP_READ:     step_of = '{1'b0, a, 16'h0000};
            FCD_OP_ESN_READ: step_of = '{1'b0, 22'((TOP_BOOT ? (bm ? `FCD_ESN_BASE_BYTE
                                        : `FCD_ESN_BASE_WORD) : `FCD_ADDR_ZERO) + a), 16'h0000};
            FCD_OP_RESET:    step_of = '{1'b1, `FCD_ADDR_ZERO, `FCD_D_RESET};
            FCD_OP_CFI:      step_of = '{1'b1, bm ? `FCD_CFI_BYTE : `FCD_CFI_WORD, `FCD_D_CFI};
            FCD_OP_SUSPEND:  step_of = '{1'b1, a, `FCD_D_SUSPEND};
            FCD_OP_RESUME:   step_of = '{1'b1, a, `FCD_D_RESUME};
            default: begin
                unique case (i)
                    3'd0:    step_of = '{1'b1, u1, `FCD_D_UNLK1};
                    3'd1:    step_of = '{1'b1, u2, `FCD_D_UNLK2};
                    3'd2: begin
                        unique case (op)
                            FCD_OP_ASEL, FCD_OP_SEC_EXIT: step_of = '{1'b1, u1, `FCD_D_ASEL};
                            FCD_OP_SEC_ENTER: step_of = '{1'b1, u1, `FCD_D_SEC_ENTER};
                            FCD_OP_PROG:      step_of = '{1'b1, u1, `FCD_D_PROG};
                            default:          step_of = '{1'b1, u1, `FCD_D_ERASE};
                        endcase
                    end
                    3'd3: begin
                        unique case (op)
                            FCD_OP_ASEL:     step_of = '{1'b0, a, 16'h0000};
                            FCD_OP_SEC_EXIT: step_of = '{1'b1, a, `FCD_D_SEC_EXIT};
                            FCD_OP_PROG:     step_of = '{1'b1, a, d};
                            default:         step_of = '{1'b1, u1, `FCD_D_UNLK1};
                        endcase
                    end
                    3'd4:    step_of = '{1'b1, u2, `FCD_D_UNLK2};
                    default: step_of = (op == FCD_OP_CHIP_ERASE) ? fcd_step_t'{1'b1, u1, `FCD_D_CHIP}
                                                                 : fcd_step_t'{1'b1, a, `FCD_D_SECT};
                endcase
            end
        endcase
    endfunction : step_of

    // index of the final bus cycle of each command
    function automatic logic [2:0] last_of(input fcd_op_t op);
        unique case (op)
            FCD_OP_SEC_ENTER:                   last_of = 3'd2;
            FCD_OP_ASEL, FCD_OP_SEC_EXIT,
            FCD_OP_PROG:                        last_of = 3'd3;
            FCD_OP_CHIP_ERASE, FCD_OP_SECT_ERASE: last_of = 3'd5;
            default:                            last_of = 3'd0;
        endcase
    endfunction : last_of

    // commands the device would reject or that would leave it in the wrong region
    function automatic logic refused(input fcd_op_t op, input logic [21:0] a);
        logic wr_arr;
        wr_arr  = (op == FCD_OP_PROG) || (op == FCD_OP_SECT_ERASE) || (op == FCD_OP_CHIP_ERASE);
        refused = supply_low
               || (op == FCD_OP_SUSPEND && !(erase_active && !erase_suspended))
               || (op == FCD_OP_RESUME && !erase_suspended)
               || (in_secure && wr_arr && sec_locked)
               || (in_secure && op == FCD_OP_CHIP_ERASE)
               || (in_secure && (op == FCD_OP_READ || wr_arr) && !in_window(a, byte_mode))
               || (!in_secure && op == FCD_OP_ESN_READ);
    endfunction : refused

    assign step = pre_rst_r ? step_of(FCD_OP_RESET, 3'd0, byte_mode, addr_r, data_r)
                            : step_of(op_r, idx_r, byte_mode, addr_r, data_r);
    assign cyc.wr    = step.wr;
    assign cyc.addr  = step.addr;
    assign cyc.wdata = step.data;

    // reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // device reset pin held low while the supply is below lockout, else at plain high level,
    // which is all the region protect step needs, so no elevated voltage is ever required
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            fl_reset_b <= 1'b0;
            rdy_d_r    <= 1'b1;
        end else begin
            fl_reset_b <= ~supply_low;
            rdy_d_r    <= fl_rdy;
        end
    end

    // command sequencer
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            st_r      <= FCD_S_PWR;
            op_r      <= FCD_OP_READ;
            addr_r    <= 22'h000000;
            data_r    <= 16'h0000;
            idx_r     <= 3'd0;
            last_r    <= 3'd0;
            pre_rst_r <= 1'b0;
            pwr_cnt_r <= 32'h0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err   <= 1'b0;
            rsp_data  <= 16'h0000;
            cyc.req   <= 1'b0;
        end else begin
            cyc.req <= 1'b0;
            unique case (st_r)
                FCD_S_PWR: begin
                    // no write strobe until power-up settles
                    if (pwr_cnt_r >= PWRUP_CYC - 1) begin
                        st_r      <= FCD_S_IDLE;
                        cmd_ready <= 1'b1;
                    end else begin
                        pwr_cnt_r <= pwr_cnt_r + 32'h1;
                    end
                end
                FCD_S_IDLE: begin
                    if (cmd_valid) begin
                        cmd_ready <= 1'b0;
                        op_r      <= cmd_op;
                        addr_r    <= cmd_addr;
                        data_r    <= cmd_data;
                        last_r    <= last_of(cmd_op);
                        // autoselect already open: go straight to the read cycle
                        idx_r     <= (cmd_op == FCD_OP_ASEL && in_autosel) ? 3'd3 : 3'd0;
                        pre_rst_r <= in_autosel && cmd_op != FCD_OP_ASEL && cmd_op != FCD_OP_RESET;
                        if (refused(cmd_op, cmd_addr)) begin
                            rsp_err   <= 1'b1;
                            rsp_valid <= 1'b1;
                            st_r      <= FCD_S_RSP;
                        end else begin
                            st_r <= FCD_S_STEP;
                        end
                    end
                end
                FCD_S_STEP: begin
                    if (fl_rdy || op_r == FCD_OP_SUSPEND) begin
                        cyc.req <= 1'b1;
                        st_r    <= FCD_S_WAIT;
                    end
                end
                FCD_S_WAIT: begin
                    // once started a sequence runs on to its last cycle; a repeated autoselect sends only its read cycle
                    if (cyc.done) begin
                        if (pre_rst_r) begin
                            pre_rst_r <= 1'b0;
                            st_r      <= FCD_S_STEP;
                        end else if (idx_r == last_r) begin
                            rsp_data  <= cyc.rdata;
                            rsp_err   <= 1'b0;
                            rsp_valid <= 1'b1;
                            st_r      <= FCD_S_RSP;
                        end else begin
                            idx_r <= idx_r + 3'd1;
                            st_r  <= FCD_S_STEP;
                        end
                    end
                end
                FCD_S_RSP: begin
                    rsp_valid <= 1'b0;
                    cmd_ready <= 1'b1;
                    st_r      <= FCD_S_IDLE;
                end
            endcase
        end
    end

    // mode tracking, updated when a sequence completes; the erase flag clears when ready rises outside a suspend
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            in_secure       <= 1'b0;
            in_autosel      <= 1'b0;
            erase_active    <= 1'b0;
            erase_suspended <= 1'b0;
        end else if (st_r == FCD_S_WAIT && cyc.done && pre_rst_r) begin
            in_autosel <= 1'b0;
        end else if (st_r == FCD_S_WAIT && cyc.done && idx_r == last_r) begin
            unique case (op_r)
                FCD_OP_SEC_ENTER:  in_secure <= 1'b1;
                FCD_OP_SEC_EXIT: begin
                    in_secure  <= 1'b0;
                    in_autosel <= 1'b0;
                end
                FCD_OP_ASEL:       in_autosel <= 1'b1;
                FCD_OP_RESET:      in_autosel <= 1'b0;
                FCD_OP_SECT_ERASE: erase_active <= 1'b1;
                FCD_OP_SUSPEND:    erase_suspended <= 1'b1;
                FCD_OP_RESUME:     erase_suspended <= 1'b0;
                default:           in_autosel <= in_autosel;
            endcase
        end else if (fl_rdy && !rdy_d_r && !erase_suspended && op_r != FCD_OP_SUSPEND) begin
            erase_active <= 1'b0;                                            // erase finished
        end
    end

    fcd_cycle u_cycle (
        .clk_sys    (clk_sys),
        .rst_sync_b (rst_sync_r),
        .cyc        (cyc),
        .fl_dq_i    (fl_dq_i),
        .fl_addr    (fl_addr),
        .fl_dq_o    (fl_dq_o),
        .fl_dq_oe   (fl_dq_oe),
        .fl_ce_b    (fl_ce_b),
        .fl_we_b    (fl_we_b),
        .fl_oe_b    (fl_oe_b)
    );

endmodule : fcd_host

// ==== verif/fcd_host_assertions.sv ====
`timescale 1ns/1ps
// protocol checks on the host pins and command port
module fcd_host_assertions
    import fcd_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        supply_low,
    input wire logic        sec_locked,
    input wire logic        cmd_valid,
    input wire fcd_op_t     cmd_op,
    input wire logic        cmd_ready,
    input wire logic        rsp_valid,
    input wire logic        rsp_err,
    input wire logic        in_secure,
    input wire logic        erase_active,
    input wire logic [21:0] fl_addr,
    input wire logic [15:0] fl_dq_o,
    input wire logic        fl_dq_oe,
    input wire logic        fl_ce_b,
    input wire logic        fl_we_b,
    input wire logic        fl_oe_b,
    input wire logic        fl_reset_b
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // a command taken on this edge
    wire tk = cmd_valid && cmd_ready;
    a_write_strobe: assert property (!fl_we_b |-> !fl_ce_b && fl_oe_b)
        else $error("write strobe outside select");
    a_read_drive: assert property (!fl_oe_b |-> !fl_dq_oe && fl_we_b)
        else $error("output strobe while driving");
    a_addr_hold: assert property (!fl_we_b |-> $stable(fl_addr) && $stable(fl_dq_o))
        else $error("address or data moved under strobe");
    a_lock_pin: assert property (supply_low |=> !fl_reset_b)
        else $error("reset pin high in lockout");
    a_lock_refuse: assert property (tk && supply_low |-> ##[1:2] rsp_valid && rsp_err)
        else $error("command taken in lockout");
    a_susp_refuse: assert property (tk && cmd_op == FCD_OP_SUSPEND && !erase_active |-> ##[1:2] rsp_err)
        else $error("suspend taken without erase");
    a_esn_refuse: assert property (tk && cmd_op == FCD_OP_ESN_READ && !in_secure |-> ##[1:2] rsp_err)
        else $error("serial read outside region");
    a_locked_prog: assert property (tk && in_secure && sec_locked && cmd_op == FCD_OP_PROG |-> ##[1:2] rsp_err)
        else $error("program into locked region");
endmodule : fcd_host_assertions

bind fcd_host fcd_host_assertions u_chk (.clk_sys, .rst_b, .supply_low, .sec_locked, .cmd_valid, .cmd_op,
    .cmd_ready, .rsp_valid, .rsp_err, .in_secure, .erase_active, .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_ce_b,
    .fl_we_b, .fl_oe_b, .fl_reset_b);

// ==== verif/fcd_flash_model.sv ====
`timescale 1ns/1ps
// flash stand-in: logs writes, answers reads, busy for 200 clocks after a 30h data write (sector erase or resume)
module fcd_flash_model (
    input  wire logic        clk_sys,
    input  wire logic [21:0] fl_addr,
    input  wire logic [15:0] fl_dq_o,
    input  wire logic        fl_ce_b,
    input  wire logic        fl_we_b,
    input  wire logic        fl_oe_b,
    output logic      [15:0] fl_dq_i,
    output logic             fl_rdy
);
    logic [21:0] la [0:63];
    logic [15:0] ld [0:63];
    int          n = 0;
    int          busy = 0;
    logic [21:0] a_lat;
    logic [15:0] q_last = 16'h0000;
    wire         rd = !fl_ce_b && !fl_oe_b;
    // address taken at the later falling strobe
    always @(negedge fl_we_b or negedge fl_ce_b) if (!fl_we_b && !fl_ce_b) a_lat = fl_addr;
    // data taken at the first rising strobe of a real write
    always @(posedge fl_we_b or posedge fl_ce_b) begin
        if (fl_oe_b && (fl_we_b ^ fl_ce_b)) begin
            la[n % 64] = a_lat;
            ld[n % 64] = fl_dq_o;
            n++;
            if (fl_dq_o[7:0] == 8'h30) busy = 200;
            if (fl_dq_o[7:0] == 8'hb0) busy = 0;
        end
    end
    // busy countdown and last read value
    always @(posedge clk_sys) begin
        if (busy > 0) busy = busy - 1;
        if (rd) q_last <= fl_dq_i;
    end
    // a released bus shows the inverse of the last value
    assign fl_dq_i = rd ? (fl_addr[15:0] ^ 16'h5a5a) : ~q_last;
    assign fl_rdy = (busy == 0);
endmodule : fcd_flash_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import fcd_pkg::*;;
    logic clk_sys = 0, rst_b = 0, byte_mode = 0, supply_low = 0, sec_locked = 0, cmd_valid = 0;
    fcd_op_t cmd_op = FCD_OP_READ;
    logic [21:0] cmd_addr = 0, fl_addr;
    logic [15:0] cmd_data = 0, rsp_data, fl_dq_i, fl_dq_o, rdat;
    logic cmd_ready, rsp_valid, rsp_err, in_secure, in_autosel, erase_active, erase_suspended, err;
    logic fl_rdy, fl_dq_oe, fl_ce_b, fl_we_b, fl_oe_b, fl_reset_b;
    int miscompares = 0, n_tests = 0, base;
    fcd_host #(.PWRUP_CYC(8)) dut_u (.clk_sys, .rst_b, .byte_mode, .supply_low, .sec_locked, .cmd_valid,
        .cmd_op, .cmd_addr, .cmd_data, .cmd_ready, .rsp_valid, .rsp_err, .rsp_data, .in_secure, .in_autosel,
        .erase_active, .erase_suspended, .fl_dq_i, .fl_rdy, .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_ce_b,
        .fl_we_b, .fl_oe_b, .fl_reset_b);
    fcd_flash_model m_u (.clk_sys, .fl_addr, .fl_dq_o, .fl_ce_b, .fl_we_b, .fl_oe_b, .fl_dq_i, .fl_rdy);
    always #2.5 clk_sys = ~clk_sys;
    task automatic chk(input logic ok, input string s);
        n_tests++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, s);
        end
    endtask : chk
    task automatic wchk(input int i, input logic [21:0] a, input logic [15:0] d);
        chk(m_u.la[(base + i) % 64] === a && m_u.ld[(base + i) % 64] === d, "bus write");
    endtask : wchk
    // one command, waits for its response
    task automatic run(input fcd_op_t op, input logic [21:0] a, input logic [15:0] d);
        int k;
        base = m_u.n;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        chk(k < 3000, "no response");
        err = rsp_err;
        rdat = rsp_data;
    endtask : run
    task automatic t_reset();
        repeat (12) @(negedge clk_sys);
        chk(fl_reset_b === 1'b0 && fl_we_b === 1'b1 && cmd_ready === 1'b0, "reset state");
        rst_b = 1'b1;
        repeat (9) @(negedge clk_sys);
        chk(cmd_ready === 1'b0 && fl_we_b === 1'b1 && fl_reset_b === 1'b1, "power-up wait");
        @(negedge clk_sys);
        chk(cmd_ready === 1'b1, "ready after power-up");
    endtask : t_reset
    task automatic t_prog();
        run(FCD_OP_PROG, 22'h001234, 16'hbeef);
        wchk(0, 22'h555, 16'haa);
        wchk(1, 22'h2aa, 16'h55);
        wchk(2, 22'h555, 16'ha0);
        wchk(3, 22'h1234, 16'hbeef);
        byte_mode = 1'b1;
        run(FCD_OP_PROG, 22'h002468, 16'h00c3);
        wchk(0, 22'haaa, 16'haa);
        wchk(1, 22'h555, 16'h55);
        wchk(2, 22'haaa, 16'ha0);
        byte_mode = 1'b0;
    endtask : t_prog
    task automatic t_refuse();
        supply_low = 1'b1;
        run(FCD_OP_PROG, 22'h000100, 16'h0001);
        chk(err === 1'b1 && m_u.n == base, "lockout write");
        supply_low = 1'b0;
        run(FCD_OP_SUSPEND, 22'h010000, 16'h0000);
        chk(err === 1'b1 && m_u.n == base, "idle suspend");
        run(FCD_OP_ESN_READ, 22'h000000, 16'h0000);
        chk(err === 1'b1, "serial read outside");
    endtask : t_refuse
    task automatic t_secure();
        run(FCD_OP_SEC_ENTER, 22'h0, 16'h0);
        wchk(2, 22'h555, 16'h88);
        chk(in_secure === 1'b1, "enter region");
        run(FCD_OP_ESN_READ, 22'h000005, 16'h0);
        chk(err === 1'b0 && rdat === 16'h5a5f, "serial read");
        run(FCD_OP_CHIP_ERASE, 22'h0, 16'h0);
        chk(err === 1'b1 && m_u.n == base, "erase in region");
        run(FCD_OP_RESET, 22'h0, 16'h0);
        wchk(0, 22'h0, 16'hf0);
        chk(err === 1'b0 && in_secure === 1'b1, "reset keeps region");
        sec_locked = 1'b1;
        run(FCD_OP_PROG, 22'h000010, 16'h1111);
        chk(err === 1'b1 && m_u.n == base, "locked program");
        sec_locked = 1'b0;
        run(FCD_OP_SEC_EXIT, 22'h0, 16'h0);
        wchk(2, 22'h555, 16'h90);
        wchk(3, 22'h0, 16'h00);
        chk(in_secure === 1'b0, "exit region");
        run(FCD_OP_SEC_ENTER, 22'h0, 16'h0);
        rst_b = 1'b0;
        @(negedge clk_sys);
        chk(in_secure === 1'b0 && fl_reset_b === 1'b0 && cmd_ready === 1'b0, "reset in region");
        rst_b = 1'b1;
    endtask : t_secure
    task automatic t_asel();
        run(FCD_OP_ASEL, 22'h000003, 16'h0);
        wchk(2, 22'h555, 16'h90);
        chk(rdat === 16'h5a59 && in_autosel === 1'b1, "autoselect read");
        run(FCD_OP_ASEL, 22'h000000, 16'h0);
        chk(m_u.n == base && rdat === 16'h5a5a, "autoselect reread");
        run(FCD_OP_READ, 22'h000010, 16'h0);
        wchk(0, 22'h0, 16'hf0);
        chk(rdat === 16'h5a4a && in_autosel === 1'b0, "array read");
        run(FCD_OP_CFI, 22'h0, 16'h0);
        wchk(0, 22'h55, 16'h98);
    endtask : t_asel
    task automatic t_erase();
        run(FCD_OP_CHIP_ERASE, 22'h0, 16'h0);
        wchk(3, 22'h555, 16'haa);
        wchk(5, 22'h555, 16'h10);
        run(FCD_OP_SECT_ERASE, 22'h010000, 16'h0);
        wchk(2, 22'h555, 16'h80);
        wchk(5, 22'h010000, 16'h30);
        chk(erase_active === 1'b1, "erase busy");
        run(FCD_OP_SUSPEND, 22'h010000, 16'h0);
        wchk(0, 22'h010000, 16'hb0);
        chk(err === 1'b0 && erase_suspended === 1'b1, "suspend");
        run(FCD_OP_RESUME, 22'h010000, 16'h0);
        chk(err === 1'b0 && erase_suspended === 1'b0, "resume");
    endtask : t_erase
    task automatic end_of_test();
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // main sequence
    initial begin
        t_reset();
        t_prog();
        t_refuse();
        t_secure();
        t_asel();
        t_erase();
        end_of_test();
    end
    // watchdog
    initial begin
        #300us;
        miscompares++;
        end_of_test();
    end
endmodule : tb_top
